// ==== verilog/ufe_device.sv ====
// function end: control, bulk-out and bulk-in endpoints with apb registers
// assumes the host end follows the link order and acks every data packet
// Function
// [RL1] mode monitor change raises enabled interrupt
// [RL2] control goes setup, optional data, status
// [RL3] firmware refills control-in after done flag
// [RL4] out token ends control-in data stage
// [RL5] control-out packet sets receive-done flag
// [RL6] in token ends control-out data stage
// [RL7] zero-length out packet completes control-in
// [RL8] empty control-in at status raises request
// [RL9] zero commit sends zero-length packet
// [RL10] two bulk-out banks seen as one
// [RL11] filled bulk-out bank sets full flag
// [RL12] both bulk-out banks full answers nak
// [RL13] reading whole packet frees its bank
// [RL14] zero-length bulk-out acked, not stored
// [RL15] short bulk-out packet occupies whole bank
// [RL16] two bulk-in banks behind one register
// [RL17] firmware commits one bank per packet
// [RL18] firmware checks empty flag before writing
// [RL19] enabling empty interrupt fires when empty
// [RL20] empty flag low only when both committed
// [RL21] host ack frees bank, next follows
// [RL22] firmware disables empty interrupt when finished
// [RL23] interrupt is any enabled flag set
//
// The APB slave port and the register addresses were decided locally.
module ufe_device
    import ufe_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb register port
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cable state and interrupt
    input wire logic [1:0] link_state_monitor,
    output logic irq,
    // usb side
    ufe_link_if.dev lk
);
    typedef struct packed {
        ufe_ctrl_st_t cst;
        ufe_link_st_t lst;
        logic [1:0] ep;
        logic nak;
        logic [8:0] flg;
        logic [8:0] ier;
        logic [1:0] mon;
        logic [6:0] o_cnt;
        logic [6:0] o_rd;
        logic [6:0] i_cnt;
        logic [6:0] i_len;
        logic i_commit;
        logic [9:0] tx_cnt;
        logic [9:0] tx_len;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic d2h_valid;
        logic [7:0] d2h_data;
        logic d2h_eop;
        logic hs_valid;
        logic hs_nak;
    } ufe_dev_state_t;

    ufe_dev_state_t s_q, s_d;
    logic [7:0] ctrl_out_mem [0:63];
    logic [7:0] ctrl_in_mem [0:63];
    logic o_we, i_we;
    logic [5:0] o_wa, i_wa;
    logic [7:0] o_wd, i_wd;
    logic bo_wr, bo_commit, bo_rd, bo_free, bo_last, bo_data, bo_space;
    logic bi_wr, bi_commit, bi_rd, bi_rew, bi_free, bi_data, bi_space;
    logic [9:0] bo_wlen, bo_len, bi_len, bi_clen;
    logic [7:0] bo_rdata, bi_rdata;
    logic [8:0] flags, clr, set;
    logic setup_ph, acc;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // bulk-out pair, drained by register reads
    ufe_dual_fifo u_bout (
        .clk(clk), .rst(rst),
        .wr_en(bo_wr), .wr_data(lk.h2d_data),
        .commit(bo_commit), .commit_len(bo_wlen),
        .wr_len(bo_wlen), .has_space(bo_space),
        .rd_en(bo_rd), .rd_rewind(1'b0), .free_bank(bo_free),
        .rd_data(bo_rdata), .rd_len(bo_len), .rd_last(bo_last),
        .has_data(bo_data)
    ); // RL10

    // bulk-in pair, filled by register writes
    ufe_dual_fifo u_bin (
        .clk(clk), .rst(rst),
        .wr_en(bi_wr), .wr_data(pwdata[7:0]),
        .commit(bi_commit), .commit_len(bi_clen),
        .wr_len(), .has_space(bi_space),
        .rd_en(bi_rd), .rd_rewind(bi_rew), .free_bank(bi_free),
        .rd_data(bi_rdata), .rd_len(bi_len), .rd_last(),
        .has_data(bi_data)
    ); // RL16

    assign setup_ph = psel && !penable;
    assign acc = psel && penable && s_q.pready;
    assign bi_clen = pwdata[9:0];

    // visible flag word: sticky bits plus live levels
    always_comb begin
        flags = s_q.flg;
        flags[BIT_OFULL] = bo_data; // RL11
        flags[BIT_IEMPTY] = bi_space; // RL20
        flags[BIT_MON0] = s_q.mon[0];
        flags[BIT_MON1] = s_q.mon[1];
    end

    // registers, link engine, control stages
    always_comb begin
        s_d = s_q;
        s_d.d2h_valid = 1'b0;
        s_d.d2h_eop = 1'b0;
        s_d.hs_valid = 1'b0;
        s_d.hs_nak = 1'b0;
        s_d.pready = setup_ph;
        clr = '0;
        set = '0;
        {o_we, i_we, bo_wr, bo_commit, bo_rd, bo_free} = '0;
        {bi_wr, bi_commit, bi_rd, bi_rew, bi_free} = '0;
        o_wa = s_q.o_cnt[5:0];
        o_wd = lk.h2d_data;
        i_wa = s_q.i_cnt[5:0];
        i_wd = pwdata[7:0];
        // read data and error set in the setup cycle
        if (setup_ph) begin
            s_d.prdata = '0;
            s_d.pslverr = 1'b0;
            if (hit(paddr, OFS_FLAGS))
                s_d.prdata = {23'h0, flags};
            else if (hit(paddr, OFS_ENABLE))
                s_d.prdata = {23'h0, s_q.ier};
            else if (hit(paddr, OFS_CTRL_DATA))
                s_d.prdata = {24'h0, ctrl_out_mem[s_q.o_rd[5:0]]};
            else if (hit(paddr, OFS_BOUT_DATA))
                s_d.prdata = {24'h0, bo_rdata};
            else if (hit(paddr, OFS_BOUT_LEN))
                s_d.prdata = {22'h0, bo_len};
            else if (!hit(paddr, OFS_CTRL_COMMIT) &&
                     !hit(paddr, OFS_BIN_DATA) &&
                     !hit(paddr, OFS_BIN_COMMIT))
                s_d.pslverr = 1'b1;
        end
        // side effects at the access edge
        if (acc && pwrite) begin
            if (hit(paddr, OFS_FLAGS))
                clr = pwdata[8:0] & STICKY_MASK;
            if (hit(paddr, OFS_ENABLE))
                s_d.ier = pwdata[8:0]; // RL19
            if (hit(paddr, OFS_CTRL_DATA) && s_q.i_cnt < CTRL_DEPTH) begin
                i_we = 1'b1;
                s_d.i_cnt = s_q.i_cnt + 7'd1;
            end
            if (hit(paddr, OFS_CTRL_COMMIT)) begin
                s_d.i_len = pwdata[6:0]; // RL9
                s_d.i_commit = 1'b1;
            end
            bi_wr = hit(paddr, OFS_BIN_DATA);
            bi_commit = hit(paddr, OFS_BIN_COMMIT); // RL17
        end
        if (acc && !pwrite) begin
            if (hit(paddr, OFS_CTRL_DATA))
                s_d.o_rd = s_q.o_rd + 7'd1;
            if (hit(paddr, OFS_BOUT_DATA) && bo_data) begin
                bo_rd = 1'b1;
                bo_free = bo_last; // RL13
            end
        end
        // cable mode monitor change
        s_d.mon = link_state_monitor;
        if (s_q.mon != link_state_monitor)
            set[BIT_MCHG] = 1'b1; // RL1
        unique case (s_q.lst)
            L_IDLE: if (lk.tok_valid) begin
                s_d.ep = lk.tok_ep;
                s_d.nak = 1'b0;
                s_d.tx_cnt = '0;
                case (lk.tok_kind)
                    TOK_SETUP: begin
                        s_d.cst = C_IDLE; // RL2
                        s_d.o_cnt = '0;
                        s_d.o_rd = '0;
                        s_d.i_cnt = '0;
                        s_d.i_commit = 1'b0;
                        s_d.nak = (lk.tok_ep != EP_CTRL);
                        s_d.lst = L_RX;
                    end
                    TOK_OUT: begin
                        s_d.lst = L_RX;
                        s_d.o_cnt = '0;
                        if (lk.tok_ep == EP_BOUT)
                            s_d.nak = !bo_space; // RL12
                        else if (lk.tok_ep != EP_CTRL)
                            s_d.nak = 1'b1;
                        else if (s_q.cst == C_DIN)
                            s_d.cst = C_STIN; // RL4
                        else if (s_q.cst == C_DOUT)
                            s_d.o_rd = '0;
                        else
                            s_d.nak = 1'b1;
                    end
                    TOK_IN: begin
                        if (lk.tok_ep == EP_CTRL && (s_q.cst == C_DIN ||
                            s_q.cst == C_DOUT || s_q.cst == C_STOUT)) begin
                            if (s_q.cst == C_DOUT)
                                s_d.cst = C_STOUT; // RL6
                            if (s_q.i_commit) begin
                                s_d.tx_len = {3'h0, s_q.i_len};
                                s_d.lst = L_TX;
                            end else begin
                                s_d.hs_valid = 1'b1;
                                s_d.hs_nak = 1'b1;
                                if (s_q.cst != C_DIN)
                                    set[BIT_REQ] = 1'b1; // RL8
                            end
                        end else if (lk.tok_ep == EP_BIN && bi_data) begin
                            bi_rew = 1'b1;
                            s_d.tx_len = bi_len;
                            s_d.lst = L_TX;
                        end else begin
                            s_d.hs_valid = 1'b1;
                            s_d.hs_nak = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            L_RX: begin
                if (lk.h2d_valid && !s_q.nak) begin
                    if (s_q.ep == EP_CTRL && s_q.o_cnt < CTRL_DEPTH) begin
                        o_we = 1'b1;
                        s_d.o_cnt = s_q.o_cnt + 7'd1;
                    end
                    bo_wr = (s_q.ep == EP_BOUT);
                end
                if (lk.h2d_eop) begin
                    s_d.lst = L_IDLE;
                    s_d.hs_valid = 1'b1;
                    s_d.hs_nak = s_q.nak;
                    if (!s_q.nak && s_q.ep == EP_CTRL) begin
                        if (s_q.cst == C_IDLE) begin
                            set[BIT_SETUP] = 1'b1;
                            s_d.cst = ctrl_out_mem[0][SETUP_DIR_BIT] ?
                                C_DIN : C_DOUT; // RL2
                        end else if (s_q.cst == C_DOUT)
                            set[BIT_RXD] = 1'b1; // RL5
                        else if (s_q.cst == C_STIN)
                            s_d.cst = C_IDLE; // RL7
                    end
                    // zero-length: acked, not stored
                    if (!s_q.nak && s_q.ep == EP_BOUT)
                        bo_commit = (bo_wlen != 10'd0); // RL14 RL15
                end
            end
            L_TX: begin
                if (s_q.tx_cnt == s_q.tx_len) begin
                    s_d.d2h_eop = 1'b1;
                    s_d.lst = L_ACKW;
                end else begin
                    s_d.d2h_valid = 1'b1;
                    s_d.d2h_data = (s_q.ep == EP_CTRL) ?
                        ctrl_in_mem[s_q.tx_cnt[5:0]] : bi_rdata;
                    bi_rd = (s_q.ep == EP_BIN);
                    s_d.tx_cnt = s_q.tx_cnt + 10'd1;
                end
            end
            L_ACKW: if (lk.h_ack) begin
                s_d.lst = L_IDLE;
                if (s_q.ep == EP_CTRL) begin
                    s_d.i_commit = 1'b0;
                    s_d.i_cnt = '0;
                    if (s_q.cst == C_DIN)
                        set[BIT_TXD] = 1'b1; // RL3
                    if (s_q.cst == C_STOUT)
                        s_d.cst = C_IDLE; // RL9
                end else
                    bi_free = 1'b1; // RL21
            end
        endcase
        // set beats clear
        s_d.flg = (s_q.flg & ~clr) | set;
        s_d.irq = |(flags & s_q.ier); // RL23 RL19
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.flg <= FLAGS_RST;
            s_q.ier <= ENABLE_RST;
        end else
            s_q <= s_d;
    end

    // control endpoint buffers
    always_ff @(posedge clk) begin
        if (o_we)
            ctrl_out_mem[o_wa] <= o_wd;
        if (i_we)
            ctrl_in_mem[i_wa] <= i_wd;
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign irq = s_q.irq;
    assign lk.d2h_valid = s_q.d2h_valid;
    assign lk.d2h_data = s_q.d2h_data;
    assign lk.d2h_eop = s_q.d2h_eop;
    assign lk.hs_valid = s_q.hs_valid;
    assign lk.hs_nak = s_q.hs_nak;
endmodule

// ==== verilog/ufe_pkg.sv ====
// constants and types shared by both link ends
// assumes a single 100 MHz clock and an apb register port on the device end
package ufe_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h04;
    localparam logic [7:0] OFS_CTRL_DATA = 8'h08;
    localparam logic [7:0] OFS_CTRL_COMMIT = 8'h0C;
    localparam logic [7:0] OFS_BOUT_DATA = 8'h10;
    localparam logic [7:0] OFS_BOUT_LEN = 8'h14;
    localparam logic [7:0] OFS_BIN_DATA = 8'h18;
    localparam logic [7:0] OFS_BIN_COMMIT = 8'h1C;
    // flag and enable bit positions
    localparam int BIT_TXD = 0;
    localparam int BIT_RXD = 1;
    localparam int BIT_REQ = 2;
    localparam int BIT_SETUP = 3;
    localparam int BIT_OFULL = 4;
    localparam int BIT_IEMPTY = 5;
    localparam int BIT_MON0 = 6;
    localparam int BIT_MON1 = 7;
    localparam int BIT_MCHG = 8;
    localparam int FLAG_W = 9;
    // sticky bits, cleared by writing one
    localparam logic [8:0] STICKY_MASK = 9'h10F;
    localparam logic [8:0] FLAGS_RST = 9'h000;
    localparam logic [8:0] ENABLE_RST = 9'h000;
    // buffer sizes
    localparam logic [9:0] BANK_DEPTH = 10'h200;
    localparam logic [6:0] CTRL_DEPTH = 7'h40;
    localparam int SETUP_DIR_BIT = 7;
    // endpoint numbers
    localparam logic [1:0] EP_CTRL = 2'h0;
    localparam logic [1:0] EP_BOUT = 2'h1;
    localparam logic [1:0] EP_BIN = 2'h2;
    typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} ufe_tok_t;
    typedef enum logic [1:0] {RES_ACK, RES_NAK, RES_DATA} ufe_res_t;
    typedef enum logic [2:0] {C_IDLE, C_DIN, C_DOUT, C_STIN, C_STOUT}
        ufe_ctrl_st_t;
    typedef enum logic [1:0] {L_IDLE, L_RX, L_TX, L_ACKW} ufe_link_st_t;
    typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} ufe_host_st_t;
endpackage

// ==== verilog/ufe_link_if.sv ====
// packet level link between usb host and function ends
// assumes both ends run on the same clock; no clocking block
interface ufe_link_if;
    logic tok_valid;
    ufe_pkg::ufe_tok_t tok_kind;
    logic [1:0] tok_ep;
    logic h2d_valid;
    logic [7:0] h2d_data;
    logic h2d_eop;
    logic h_ack;
    logic d2h_valid;
    logic [7:0] d2h_data;
    logic d2h_eop;
    logic hs_valid;
    logic hs_nak;
    modport host (output tok_valid, tok_kind, tok_ep, h2d_valid, h2d_data,
        h2d_eop, h_ack, input d2h_valid, d2h_data, d2h_eop, hs_valid,
        hs_nak);
    modport dev (input tok_valid, tok_kind, tok_ep, h2d_valid, h2d_data,
        h2d_eop, h_ack, output d2h_valid, d2h_data, d2h_eop, hs_valid,
        hs_nak);
endinterface

// ==== verilog/ufe_dual_fifo.sv ====
// two packet banks of 512 bytes seen as one byte queue
// assumes the owner commits and frees whole packets
module ufe_dual_fifo
    import ufe_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic commit,
    input wire logic [9:0] commit_len,
    output logic [9:0] wr_len,
    output logic has_space,
    // drain side
    input wire logic rd_en,
    input wire logic rd_rewind,
    input wire logic free_bank,
    output logic [7:0] rd_data,
    output logic [9:0] rd_len,
    output logic rd_last,
    output logic has_data
);
    typedef struct packed {
        logic wb;
        logic rb;
        logic [9:0] wptr;
        logic [9:0] rptr;
        logic [1:0] full;
        logic [1:0][9:0] len;
    } ufe_fifo_state_t;

    ufe_fifo_state_t s_q, s_d;
    logic [7:0] mem [0:1023];
    logic we;

    // byte lands in an open bank with room
    assign we = wr_en && !s_q.full[s_q.wb] && (s_q.wptr < BANK_DEPTH);

    // pointer and bank bookkeeping per packet
    always_comb begin
        s_d = s_q;
        if (we)
            s_d.wptr = s_q.wptr + 10'd1;
        if (commit && !s_q.full[s_q.wb]) begin
            s_d.full[s_q.wb] = 1'b1;
            s_d.len[s_q.wb] = commit_len;
            s_d.wb = ~s_q.wb;
            s_d.wptr = '0;
        end
        if (rd_en)
            s_d.rptr = s_q.rptr + 10'd1;
        if (rd_rewind)
            s_d.rptr = '0;
        if (free_bank && s_q.full[s_q.rb]) begin
            s_d.full[s_q.rb] = 1'b0;
            s_d.rb = ~s_q.rb;
            s_d.rptr = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // packet storage
    always_ff @(posedge clk) begin
        if (we)
            mem[{s_q.wb, s_q.wptr[8:0]}] <= wr_data;
    end

    assign rd_data = mem[{s_q.rb, s_q.rptr[8:0]}];
    assign rd_len = s_q.len[s_q.rb];
    assign rd_last = (s_q.rptr == s_q.len[s_q.rb] - 10'd1);
    assign has_data = s_q.full[s_q.rb];
    assign has_space = !(&s_q.full);
    assign wr_len = s_q.wptr;
endmodule

// ==== verilog/ufe_host.sv ====
// usb host end: issues one token per command and runs its data phase
// assumes the user holds out_data valid for index out_idx
module ufe_host
    import ufe_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command port
    input wire logic cmd_valid,
    input wire ufe_pkg::ufe_tok_t cmd_kind,
    input wire logic [1:0] cmd_ep,
    input wire logic [9:0] cmd_len,
    output logic cmd_ready,
    // out data source
    input wire logic [7:0] out_data,
    output logic [9:0] out_idx,
    // results
    output logic res_valid,
    output ufe_pkg::ufe_res_t res_code,
    output logic rx_valid,
    output logic [7:0] rx_data,
    // usb side
    ufe_link_if.host lk
);
    typedef struct packed {
        ufe_host_st_t st;
        ufe_tok_t kind;
        logic [1:0] ep;
        logic [9:0] len;
        logic [9:0] cnt;
        logic tok_valid;
        logic h2d_valid;
        logic [7:0] h2d_data;
        logic h2d_eop;
        logic h_ack;
        logic res_valid;
        ufe_res_t res_code;
        logic rx_valid;
        logic [7:0] rx_data;
    } ufe_host_state_t;

    ufe_host_state_t s_q, s_d;

    // token, data phase and handshake sequencing
    always_comb begin
        s_d = s_q;
        s_d.tok_valid = 1'b0;
        s_d.h2d_valid = 1'b0;
        s_d.h2d_eop = 1'b0;
        s_d.h_ack = 1'b0;
        s_d.res_valid = 1'b0;
        s_d.rx_valid = 1'b0;
        unique case (s_q.st)
            H_IDLE: if (cmd_valid) begin
                s_d.kind = cmd_kind;
                s_d.ep = cmd_ep;
                s_d.len = cmd_len;
                s_d.cnt = '0;
                s_d.tok_valid = 1'b1; // RL2
                s_d.st = (cmd_kind == TOK_IN) ? H_WAIT : H_SEND;
            end
            H_SEND: begin
                if (s_q.cnt == s_q.len) begin
                    s_d.h2d_eop = 1'b1; // RL7
                    s_d.st = H_WAIT;
                end else begin
                    s_d.h2d_valid = 1'b1;
                    s_d.h2d_data = out_data;
                    s_d.cnt = s_q.cnt + 10'd1;
                end
            end
            H_WAIT: begin
                if (lk.hs_valid) begin
                    s_d.res_valid = 1'b1;
                    s_d.res_code = lk.hs_nak ? RES_NAK : RES_ACK;
                    s_d.st = H_IDLE;
                end else if (lk.d2h_valid) begin
                    s_d.rx_valid = 1'b1;
                    s_d.rx_data = lk.d2h_data;
                end else if (lk.d2h_eop) begin
                    s_d.h_ack = 1'b1; // RL21
                    s_d.res_valid = 1'b1;
                    s_d.res_code = RES_DATA;
                    s_d.st = H_IDLE;
                end
            end
            default: s_d.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign cmd_ready = (s_q.st == H_IDLE);
    assign out_idx = s_q.cnt;
    assign res_valid = s_q.res_valid;
    assign res_code = s_q.res_code;
    assign rx_valid = s_q.rx_valid;
    assign rx_data = s_q.rx_data;
    assign lk.tok_valid = s_q.tok_valid;
    assign lk.tok_kind = s_q.kind;
    assign lk.tok_ep = s_q.ep;
    assign lk.h2d_valid = s_q.h2d_valid;
    assign lk.h2d_data = s_q.h2d_data;
    assign lk.h2d_eop = s_q.h2d_eop;
    assign lk.h_ack = s_q.h_ack;
endmodule

// ==== dv/ufe_chk.sv ====
// link checker: timing of tokens, data and handshakes
// assumes one clock, beside the link interface
module ufe_chk
    import ufe_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host to device
    input wire logic tok_valid,
    input wire ufe_pkg::ufe_tok_t tok_kind,
    input wire logic [1:0] tok_ep,
    input wire logic h2d_valid,
    input wire logic h2d_eop,
    input wire logic h_ack,
    // device to host
    input wire logic d2h_valid,
    input wire logic d2h_eop,
    input wire logic hs_valid,
    input wire logic hs_nak
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // token steps
    sequence s_zlp_bout;
        tok_valid && tok_kind == TOK_OUT && tok_ep == EP_BOUT ##1 h2d_eop;
    endsequence
    sequence s_in_tok;
        tok_valid && tok_kind == TOK_IN;
    endsequence
    // handshake and data answers
    a_zlp_acked: assert property (s_zlp_bout |=> hs_valid && !hs_nak)
        else $error("zlp not acked");
    a_hs_after_eop: assert property (h2d_eop |=> hs_valid)
        else $error("no handshake");
    a_in_answer: assert property (s_in_tok |=>
        hs_valid or ##1 (d2h_valid || d2h_eop))
        else $error("in unanswered");
    a_in_nak: assert property (s_in_tok ##1 hs_valid |-> hs_nak)
        else $error("in hs not nak");
    a_tx_contig: assert property (d2h_valid |=> d2h_valid || d2h_eop)
        else $error("tx gap");
    a_ack_follows: assert property (d2h_eop |=> h_ack)
        else $error("no host ack");
    a_tok_quiet: assert property (tok_valid |->
        !h2d_valid && !d2h_valid)
        else $error("token overlaps data");
    a_hs_cause: assert property (hs_valid |->
        $past(h2d_eop) || $past(tok_valid))
        else $error("hs without cause");
endmodule

// ==== dv/testbench.sv ====
// bench: host and function ends on one link
// assumes design files and checker compiled first
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ufe_pkg::*;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cmd_valid = 0;
    logic pready, pslverr, irq, cmd_ready, res_valid, rx_valid;
    logic [1:0] mon = 0, cmd_ep = 0;
    logic [7:0] paddr = 0, rx_data, mem[16];
    logic [9:0] cmd_len = 0, out_idx;
    logic [31:0] pwdata = 0, prdata, seed = 32'h0000_E751, exp_q[$], msk_q[$];
    ufe_tok_t cmd_kind = TOK_OUT;
    ufe_res_t res_code;
    int err_count = 0, comparisons = 0, n1, n2;
    ufe_link_if lk_if();
    // both ends and the checker
    ufe_device ufe_device_inst (.clk, .rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .link_state_monitor(mon), .irq,
        .lk(lk_if.dev));
    ufe_host ufe_host_inst (.clk, .rst, .cmd_valid, .cmd_kind, .cmd_ep,
        .cmd_len, .cmd_ready, .out_data(mem[out_idx[3:0]]), .out_idx,
        .res_valid, .res_code, .rx_valid, .rx_data, .lk(lk_if.host));
    ufe_chk ufe_chk_inst (.clk, .rst, .tok_valid(lk_if.tok_valid),
        .tok_kind(lk_if.tok_kind), .tok_ep(lk_if.tok_ep),
        .h2d_valid(lk_if.h2d_valid), .h2d_eop(lk_if.h2d_eop),
        .h_ack(lk_if.h_ack), .d2h_valid(lk_if.d2h_valid),
        .d2h_eop(lk_if.d2h_eop), .hs_valid(lk_if.hs_valid),
        .hs_nak(lk_if.hs_nak));
    // clock
    initial forever #5 clk = ~clk;
    // xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // comparison and verdict
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (exp_q.size() != 0) err_count++;
        $display("comparisons=%0d errors=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // bounded wait
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 500; i++) begin
            @(negedge clk);
            if (s === 1'b1) return;
        end
        err_count++;
        final_report();
    endtask
    task automatic note(logic [31:0] v, logic [31:0] m);
        exp_q.push_back(v);
        msk_q.push_back(m);
    endtask
    // apb transfer
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        wait_hi(pready);
        @(posedge clk);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] v, logic [31:0] m);
        note(v, m);
        apb(0, a, 0);
    endtask
    // one host command
    task automatic host(ufe_tok_t k, logic [1:0] ep, logic [9:0] n);
        @(posedge clk);
        cmd_valid <= 1;
        cmd_kind <= k;
        cmd_ep <= ep;
        cmd_len <= n;
        wait_hi(cmd_ready);
        @(posedge clk);
        cmd_valid <= 0;
        wait_hi(res_valid);
    endtask
    task automatic pkt_out(ufe_tok_t k, logic [1:0] ep, int n, ufe_res_t r);
        note(32'(r), 32'h3);
        host(k, ep, 10'(n));
    endtask
    task automatic pkt_in(logic [1:0] ep, int base, int n);
        for (int j = 0; j < n; j++) note(32'(mem[base + j]), 32'hFF);
        note(32'(RES_DATA), 32'h3);
        host(TOK_IN, ep, 0);
    endtask
    task automatic chk_irq(logic v);
        repeat (3) @(negedge clk);
        check(32'(irq), 32'(v));
    endtask
    // watcher
    task automatic take(logic [31:0] v);
        logic [31:0] m;
        if (exp_q.size() == 0) check(v, ~v);
        if (exp_q.size() == 0) return;
        m = msk_q.pop_front();
        check(v & m, exp_q.pop_front() & m);
    endtask
    always @(negedge clk) begin
        if (!rst && psel && penable && pready && !pwrite)
            take(prdata | {pslverr, 31'h0});
        if (res_valid) take(32'(res_code));
        if (rx_valid) take(32'(rx_data));
    end
    // main sequence
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = rnd();
        n1 = 1 + rnd() % 8;
        n2 = 1 + rnd() % 8;
        repeat (6) @(posedge clk);
        rst <= 0;
        rd(OFS_FLAGS, 32'h20, 32'h1FF);
        pkt_out(TOK_OUT, EP_BOUT, 0, RES_ACK);
        rd(OFS_FLAGS, 32'h0, 32'h10);
        pkt_out(TOK_OUT, EP_BOUT, n1, RES_ACK);
        pkt_out(TOK_OUT, EP_BOUT, n2, RES_ACK);
        pkt_out(TOK_OUT, EP_BOUT, 3, RES_NAK);
        rd(OFS_FLAGS, 32'h10, 32'h10);
        rd(OFS_BOUT_LEN, 32'(n1), 32'h3FF);
        for (int j = 0; j < n1; j++)
            rd(OFS_BOUT_DATA, 32'(mem[j]), 32'hFF);
        pkt_out(TOK_OUT, EP_BOUT, 4, RES_ACK);
        apb(1, OFS_ENABLE, 32'h20);
        chk_irq(1);
        for (int j = 0; j < n1; j++) apb(1, OFS_BIN_DATA, 32'(mem[j]));
        apb(1, OFS_BIN_COMMIT, 32'(n1));
        for (int j = 0; j < n2; j++) apb(1, OFS_BIN_DATA, 32'(mem[j + 8]));
        apb(1, OFS_BIN_COMMIT, 32'(n2));
        rd(OFS_FLAGS, 32'h0, 32'h20);
        chk_irq(0);
        pkt_in(EP_BIN, 0, n1);
        rd(OFS_FLAGS, 32'h20, 32'h20);
        pkt_in(EP_BIN, 8, n2);
        apb(1, OFS_ENABLE, 32'h0);
        mem[0] <= 8'h00;
        pkt_out(TOK_SETUP, EP_CTRL, 8, RES_ACK);
        pkt_out(TOK_OUT, EP_CTRL, 2, RES_ACK);
        for (int j = 0; j < 2; j++)
            rd(OFS_CTRL_DATA, 32'(mem[j]), 32'hFF);
        pkt_out(TOK_IN, EP_CTRL, 0, RES_NAK);
        rd(OFS_FLAGS, 32'h6, 32'h6);
        apb(1, OFS_CTRL_COMMIT, 32'h0);
        pkt_in(EP_CTRL, 0, 0);
        mem[0] <= 8'h80;
        pkt_out(TOK_SETUP, EP_CTRL, 8, RES_ACK);
        apb(1, OFS_CTRL_DATA, 32'(mem[1]));
        apb(1, OFS_CTRL_COMMIT, 32'h1);
        pkt_in(EP_CTRL, 1, 1);
        rd(OFS_FLAGS, 32'h1, 32'h1);
        pkt_out(TOK_OUT, EP_CTRL, 0, RES_ACK);
        rd(8'hF0, 32'h8000_0000, 32'hFFFF_FFFF);
        apb(1, OFS_ENABLE, 32'h100);
        mon <= 2'b10;
        chk_irq(1);
        apb(1, OFS_FLAGS, 32'h100);
        chk_irq(0);
        repeat (5) @(posedge clk);
        final_report();
    end
endmodule
